// ===== hbc_core.sv
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - switches follow direction pins or software bits, picked by a config bit
// - enable pin active high, shared pin active low; either off gives high impedance
// - shared pin is an enable after reset; flag mode bit makes it open-drain flag
// - config ports work regardless of shared pin level or mode
// - open direction or disable pins read high, open enable reads low
// - 1/0 forward, 0/1 reverse, 0/0 both low, 1/1 both high
// - flag high in normal and limiting; low when disabled, undervoltage or lockout
// - channel enable bits reset to one; outputs follow only when both set
// - two software channel enable bits beside the enable pins
// - limit level chosen by software; trip levels scale with it
// - low side over limit for blanking time: recirculate via high side, latch flag
// - current limiting sets only its diagnostic bit, never the status flag
// - low side over trip past filter time inside blanking: lockout, short to supply
// - high side over trip past filter time: lockout, short to ground
// - both active stages over current at once: lockout, shorted load
// - overtemperature: lockout and overtemp bit
// - lockout left on enable rising with shared low, or shared falling with enable high
module hbc_core
   import hbc_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic enable_i,
   input wire logic disable_or_flag_pin_i,
   input wire logic direction_input_a_i,
   input wire logic direction_input_b_i,
   input wire hbc_cfg_s cfg_i,
   input wire logic cfg_write_i,
   input wire hbc_sense_s sense_i,
   input wire logic overtemp_i,
   input wire logic supply_undervoltage_i,
   output logic disable_or_flag_pin_o,
   output logic disable_or_flag_pin_oe_o,
   output hbc_drive_e bridge_output_a_o,
   output hbc_drive_e bridge_output_b_o,
   output hbc_cfg_s cfg_o,
   output hbc_diag_s diag_o,
   output logic lockout_o,
   output logic [1:0] trip_level_o
);
   hbc_cfg_s cfg;
   hbc_diag_s diag;
   logic lockout;
   logic en_q;
   logic dis_q;
   logic [CNT_W-1:0] blank_cnt [2];
   logic [CNT_W-1:0] ls_filt [2];
   logic [CNT_W-1:0] hs_filt [2];
   logic [CNT_W-1:0] recirc_cnt [2];
   logic [1:0] recirc;
   logic [1:0] limit_hit;
   logic [1:0] ls_fault;
   logic [1:0] hs_fault;
   logic [1:0] load_fault;
   logic dis_in;
   logic active;
   logic reenable;
   logic dir_a;
   logic dir_b;
   hbc_drive_e next_a;
   hbc_drive_e next_b;

   // config held separately from pin levels, so writes work in any pin mode
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         cfg <= '0;
         cfg.flag_mode_bit <= CFG_FLAG_MODE_RST;
         cfg.channel_enable_a <= CFG_CHAN_EN_RST;
         cfg.channel_enable_b <= CFG_CHAN_EN_RST;
      end
      else if (cfg_write_i)
      begin
         cfg <= cfg_i;
      end
   end

   // in flag mode the shared pin is an output and no longer disables
   assign dis_in = cfg.flag_mode_bit ? 1'b0 : disable_or_flag_pin_i;
   assign active = enable_i && !dis_in && cfg.channel_enable_a && cfg.channel_enable_b && !lockout
      && !supply_undervoltage_i;
   assign reenable = (enable_i && !en_q && !dis_in) || (!dis_in && dis_q && enable_i);
   assign dir_a = cfg.spi_control ? cfg.spi_dir_a : direction_input_a_i;
   assign dir_b = cfg.spi_control ? cfg.spi_dir_b : direction_input_b_i;

   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         en_q <= 1'b0;
         dis_q <= 1'b1;
      end
      else
      begin
         en_q <= enable_i;
         dis_q <= dis_in;
      end
   end

   // per-channel limiting and fault filters; channel a pairs LS a with HS a
   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : g_ch
         logic dir_g;
         assign dir_g = (g == 0) ? dir_a : dir_b;
         always_ff @(posedge clk_i)
         begin
            if (sys_rst_i || !active)
            begin
               blank_cnt[g] <= '0;
               ls_filt[g] <= '0;
               hs_filt[g] <= '0;
               recirc_cnt[g] <= '0;
            end
            else
            begin
               if (recirc_cnt[g] != '0)
                  recirc_cnt[g] <= recirc_cnt[g] - 1'b1;
               else if (limit_hit[g])
                  recirc_cnt[g] <= CNT_W'(RECIRC_CYC);
               if (sense_i.ls_over_limit[g] && !dir_g && recirc_cnt[g] == '0)
                  blank_cnt[g] <= (blank_cnt[g] == CNT_W'(BLANK_CYC)) ? '0 : blank_cnt[g] + 1'b1;
               else
                  blank_cnt[g] <= '0;
               if (sense_i.ls_over_trip[g] && blank_cnt[g] != '0)
                  ls_filt[g] <= ls_filt[g] + 1'b1;
               else
                  ls_filt[g] <= '0;
               if (sense_i.hs_over_trip[g] && dir_g)
                  hs_filt[g] <= hs_filt[g] + 1'b1;
               else
                  hs_filt[g] <= '0;
            end
         end
         assign recirc[g] = recirc_cnt[g] != '0;
         assign limit_hit[g] = blank_cnt[g] == CNT_W'(BLANK_CYC);
         assign ls_fault[g] = ls_filt[g] >= CNT_W'(FILTER_CYC);
         assign hs_fault[g] = hs_filt[g] >= CNT_W'(FILTER_CYC);
      end
   endgenerate

   // shorted load: active HS of one channel and active LS of the other both over current
   assign load_fault[0] = active && sense_i.hs_over_trip[0] && dir_a && sense_i.ls_over_limit[1] && !dir_b;
   assign load_fault[1] = active && sense_i.hs_over_trip[1] && dir_b && sense_i.ls_over_limit[0] && !dir_a;

   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         lockout <= 1'b0;
         diag <= '0;
      end
      else if (reenable && !lockout_src())
      begin
         lockout <= 1'b0;
         diag <= '0;
      end
      else
      begin
         if (lockout_src())
            lockout <= 1'b1;
         if (load_fault != '0)
            diag.shorted_load <= diag.shorted_load | load_fault;
         else
         begin
            diag.short_to_supply <= diag.short_to_supply | ls_fault;
            diag.short_to_ground <= diag.short_to_ground | hs_fault;
         end
         diag.peak_limit_flag <= diag.peak_limit_flag | limit_hit;
         diag.overtemp_flag <= diag.overtemp_flag | overtemp_i;
      end
   end

   function automatic logic lockout_src();
      lockout_src = (ls_fault != '0) || (hs_fault != '0) || (load_fault != '0) || overtemp_i;
   endfunction

   // drive decode; recirculation turns LS off and the paired HS on
   always_comb
   begin
      next_a = HBC_OFF;
      next_b = HBC_OFF;
      if (active && !lockout_src())
      begin
         next_a = (dir_a || recirc[0]) ? HBC_HIGH : HBC_LOW;
         next_b = (dir_b || recirc[1]) ? HBC_HIGH : HBC_LOW;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         bridge_output_a_o <= HBC_OFF;
         bridge_output_b_o <= HBC_OFF;
      end
      else
      begin
         bridge_output_a_o <= next_a;
         bridge_output_b_o <= next_b;
      end
   end

   // open drain flag: pulled low when off, undervoltage or locked out, never for limiting
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         disable_or_flag_pin_o <= 1'b0;
         disable_or_flag_pin_oe_o <= 1'b0;
      end
      else
      begin
         disable_or_flag_pin_o <= 1'b0;
         disable_or_flag_pin_oe_o <= cfg.flag_mode_bit && (!enable_i || supply_undervoltage_i || lockout
            || lockout_src());
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         // copies start from the same reset state as the live registers
         cfg_o <= '0;
         cfg_o.flag_mode_bit <= CFG_FLAG_MODE_RST;
         cfg_o.channel_enable_a <= CFG_CHAN_EN_RST;
         cfg_o.channel_enable_b <= CFG_CHAN_EN_RST;
         diag_o <= '0;
         lockout_o <= 1'b0;
         trip_level_o <= '0;
      end
      else
      begin
         cfg_o <= cfg;
         diag_o <= diag;
         lockout_o <= lockout;
         trip_level_o <= cfg.current_limit_select;
      end
   end

   property p_lock_off;
      @(posedge clk_i) disable iff (sys_rst_i)
         lockout |=> bridge_output_a_o == HBC_OFF && bridge_output_b_o == HBC_OFF;
   endproperty
   a_lock_off: assert property (p_lock_off) else $error("outputs driven during lockout");
   property p_fwd;
      @(posedge clk_i) disable iff (sys_rst_i)
         active && !lockout_src() && dir_a && !dir_b && !recirc[1] |=> bridge_output_a_o == HBC_HIGH
         && bridge_output_b_o == HBC_LOW;
   endproperty
   a_fwd: assert property (p_fwd) else $error("forward decode wrong");
   property p_dis;
      @(posedge clk_i) disable iff (sys_rst_i) !enable_i |=> bridge_output_a_o == HBC_OFF;
   endproperty
   a_dis: assert property (p_dis) else $error("output active while disabled");
   property p_flag;
      @(posedge clk_i) disable iff (sys_rst_i) !cfg.flag_mode_bit |=> !disable_or_flag_pin_oe_o;
   endproperty
   a_flag: assert property (p_flag) else $error("pin driven in enable mode");
   property p_ot;
      @(posedge clk_i) disable iff (sys_rst_i) overtemp_i |=> lockout && diag.overtemp_flag;
   endproperty
   a_ot: assert property (p_ot) else $error("overtemp not latched");
   property p_hold;
      @(posedge clk_i) disable iff (sys_rst_i) lockout && !reenable |=> lockout;
   endproperty
   a_hold: assert property (p_hold) else $error("lockout left without re-enable");
   property p_lim;
      @(posedge clk_i) disable iff (sys_rst_i) limit_hit != 2'b00 && active
         |=> (recirc & $past(limit_hit)) == $past(limit_hit)
         && (diag.peak_limit_flag & $past(limit_hit)) == $past(limit_hit);
   endproperty
   a_lim: assert property (p_lim) else $error("limit not handled");
   property p_chan;
      @(posedge clk_i) disable iff (sys_rst_i) !cfg.channel_enable_a |=> bridge_output_b_o == HBC_OFF;
   endproperty
   a_chan: assert property (p_chan) else $error("output active with channel off");
   // limiting alone must never pull the shared pin low
   property p_lim_no_flag;
      @(posedge clk_i) disable iff (sys_rst_i)
         limit_hit != 2'b00 && active && !lockout_src() |=> !disable_or_flag_pin_oe_o;
   endproperty
   a_lim_no_flag: assert property (p_lim_no_flag) else $error("flag raised by current limiting");
   property p_rev;
      @(posedge clk_i) disable iff (sys_rst_i)
         active && !lockout_src() && !dir_a && dir_b && !recirc[0] |=> bridge_output_a_o == HBC_LOW
         && bridge_output_b_o == HBC_HIGH;
   endproperty
   a_rev: assert property (p_rev) else $error("reverse decode wrong");
   property p_short_sup;
      @(posedge clk_i) disable iff (sys_rst_i) ls_fault != 2'b00 && load_fault == 2'b00
         |=> lockout && (diag.short_to_supply & $past(ls_fault)) == $past(ls_fault);
   endproperty
   a_short_sup: assert property (p_short_sup) else $error("low side trip not latched");
   property p_short_gnd;
      @(posedge clk_i) disable iff (sys_rst_i) hs_fault != 2'b00 && load_fault == 2'b00
         |=> lockout && (diag.short_to_ground & $past(hs_fault)) == $past(hs_fault);
   endproperty
   a_short_gnd: assert property (p_short_gnd) else $error("high side trip not latched");
   property p_load;
      @(posedge clk_i) disable iff (sys_rst_i) load_fault != 2'b00
         |=> lockout && (diag.shorted_load & $past(load_fault)) == $past(load_fault);
   endproperty
   a_load: assert property (p_load) else $error("shorted load not latched");
endmodule
`default_nettype wire

// ===== hbc_pkg.sv
package hbc_pkg;
   // drive state of one half bridge
   typedef enum logic [1:0] {HBC_OFF, HBC_LOW, HBC_HIGH} hbc_drive_e;

   // configuration bits written by software (no bus: plain ports)
   typedef struct packed {
      logic       flag_mode_bit;
      logic       spi_control;
      logic       spi_dir_a;
      logic       spi_dir_b;
      logic       channel_enable_a;
      logic       channel_enable_b;
      logic [1:0] current_limit_select;
   } hbc_cfg_s;

   // per-stage current comparator inputs
   typedef struct packed {
      logic [1:0] ls_over_limit;
      logic [1:0] ls_over_trip;
      logic [1:0] hs_over_trip;
   } hbc_sense_s;

   // latched diagnostics
   typedef struct packed {
      logic [1:0] short_to_supply;
      logic [1:0] short_to_ground;
      logic [1:0] shorted_load;
      logic [1:0] peak_limit_flag;
      logic       overtemp_flag;
   } hbc_diag_s;

   localparam logic CFG_FLAG_MODE_RST = 1'b0;
   localparam logic CFG_CHAN_EN_RST = 1'b1;
   localparam int CLK_PERIOD_NS = 25;
   localparam int BLANKING_TIME_NS = 2000;
   localparam int RECIRCULATION_TIME_NS = 10000;
   localparam int FAULT_FILTER_TIME_NS = 1000;
   localparam int BLANK_CYC = (BLANKING_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RECIRC_CYC = (RECIRCULATION_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FILTER_CYC = (FAULT_FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 10;
endpackage

// ===== hbc_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module hbc_host_model
   import hbc_pkg::*;
#(
   parameter int HOLD_CYC = (2000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS
)
(
   input wire logic clk_i,
   input wire logic flag_i,
   input wire logic flag_oe_i,
   output logic enable_o,
   output logic pin_o,
   output logic dir_a_o,
   output logic dir_b_o
);
   logic pin_drv;
   // open-drain pin: device pulls low, else host level or pull-up
   assign pin_o = flag_oe_i ? flag_i : pin_drv;
   initial
   begin
      // open-pin levels until the host drives
      enable_o = 1'b0;
      pin_drv = 1'b1;
      dir_a_o = 1'b1;
      dir_b_o = 1'b1;
   end
   task automatic set_pins(input logic [3:0] p);
      @(posedge clk_i);
      #2;
      {enable_o, pin_drv, dir_a_o, dir_b_o} = p;
   endtask
   // hold the off level, then give the enabling edge
   task automatic reenable(input logic via_pin);
      @(posedge clk_i);
      #2;
      if (via_pin)
         pin_drv = 1'b1;
      else
         enable_o = 1'b0;
      repeat (HOLD_CYC) @(posedge clk_i);
      #2;
      if (via_pin)
         pin_drv = 1'b0;
      else
         enable_o = 1'b1;
   endtask
endmodule
`default_nettype wire

// ===== tb_hbridge_control_protection.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin miscompares++; \
   $display("BAD %s exp %0h got %0h", n, e, g); end end
module tb_hbridge_control_protection
   import hbc_pkg::*;
;
   typedef struct packed {
      logic [3:0] pins;
      hbc_cfg_s cfg;
      hbc_drive_e out_a;
      hbc_drive_e out_b;
   } hbc_row_s;
   logic clk_i, sys_rst_i, cfg_write_i, overtemp_i, supply_undervoltage_i;
   logic en, pin, dir_a, dir_b, flag, flag_oe, lockout;
   logic [1:0] trip;
   hbc_cfg_s cfg_i, cfg_o;
   hbc_sense_s sense_i;
   hbc_diag_s diag_o;
   hbc_drive_e out_a, out_b;
   int miscompares = 0;
   int compares = 0;
   hbc_row_s rows [10] = '{'{4'hA, 8'h0C, HBC_HIGH, HBC_LOW}, '{4'h9, 8'h0D, HBC_LOW, HBC_HIGH},
      '{4'h8, 8'h0E, HBC_LOW, HBC_LOW}, '{4'hB, 8'h0F, HBC_HIGH, HBC_HIGH}, '{4'h2, 8'h0C, HBC_OFF, HBC_OFF},
      '{4'hE, 8'h0C, HBC_OFF, HBC_OFF}, '{4'hA, 8'h08, HBC_OFF, HBC_OFF}, '{4'hA, 8'h04, HBC_OFF, HBC_OFF},
      '{4'h9, 8'h6C, HBC_HIGH, HBC_LOW}, '{4'h9, 8'h5C, HBC_LOW, HBC_HIGH}};
   logic [5:0] faults [4] = '{6'h01, 6'h28, 6'h21, 6'h00};
   logic [8:0] masks [4] = '{9'h020, 9'h100, 9'h018, 9'h001};
   initial
   begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   hbc_host_model host_u (.clk_i(clk_i), .flag_i(flag), .flag_oe_i(flag_oe), .enable_o(en), .pin_o(pin),
      .dir_a_o(dir_a), .dir_b_o(dir_b));
   hbc_core dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .enable_i(en), .disable_or_flag_pin_i(pin),
      .direction_input_a_i(dir_a), .direction_input_b_i(dir_b), .cfg_i(cfg_i), .cfg_write_i(cfg_write_i),
      .sense_i(sense_i), .overtemp_i(overtemp_i), .supply_undervoltage_i(supply_undervoltage_i),
      .disable_or_flag_pin_o(flag), .disable_or_flag_pin_oe_o(flag_oe), .bridge_output_a_o(out_a),
      .bridge_output_b_o(out_b), .cfg_o(cfg_o), .diag_o(diag_o), .lockout_o(lockout), .trip_level_o(trip));
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #2;
   endtask
   task automatic wcfg(input hbc_cfg_s c);
      @(posedge clk_i);
      #2;
      cfg_i = c;
      cfg_write_i = 1'b1;
      cyc(1);
      cfg_write_i = 1'b0;
      cyc(2);
   endtask
   task automatic complete_run;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge clk_i);
      miscompares++;
      complete_run();
   end
   initial
   begin
      {sys_rst_i, cfg_write_i, overtemp_i, supply_undervoltage_i} = 4'h8;
      cfg_i = '0;
      sense_i = '0;
      cyc(5);
      sys_rst_i = 1'b0;
      cyc(1);
      `CHK("cfg_o", 8'h0C, cfg_o)
      `CHK("out_a", HBC_OFF, out_a)
      `CHK("out_b", HBC_OFF, out_b)
      foreach (rows[i])
      begin
         host_u.set_pins(rows[i].pins);
         wcfg(rows[i].cfg);
         `CHK("cfg_o", rows[i].cfg, cfg_o)
         `CHK("out_a", rows[i].out_a, out_a)
         `CHK("out_b", rows[i].out_b, out_b)
         `CHK("trip", rows[i].cfg.current_limit_select, trip)
      end
      $display("test table finished");
      wcfg(8'h8C);
      host_u.set_pins(4'hE);
      cyc(2);
      `CHK("out_a", HBC_HIGH, out_a)
      sense_i.ls_over_limit = 2'b10;
      cyc(BLANK_CYC + 4);
      `CHK("out_b", HBC_HIGH, out_b)
      `CHK("limit", 1'b1, diag_o.peak_limit_flag[1])
      `CHK("oe", 1'b0, flag_oe)
      sense_i = '0;
      cyc(RECIRC_CYC + 4);
      `CHK("out_b", HBC_LOW, out_b)
      `CHK("lockout", 1'b0, lockout)
      supply_undervoltage_i = 1'b1;
      cyc(3);
      `CHK("oe", 1'b1, flag_oe)
      `CHK("out_a", HBC_OFF, out_a)
      `CHK("flag", 1'b0, flag)
      supply_undervoltage_i = 1'b0;
      cyc(3);
      `CHK("out_a", HBC_HIGH, out_a)
      host_u.set_pins(4'h6);
      cyc(2);
      `CHK("oe", 1'b1, flag_oe)
      $display("test limit and flag finished");
      for (int k = 0; k < 4; k++)
      begin
         wcfg(k < 3 ? 8'h8C : 8'h0C);
         host_u.set_pins(k < 3 ? 4'hE : 4'hA);
         cyc(2);
         sense_i = faults[k];
         overtemp_i = (k == 3);
         cyc(FILTER_CYC + 4);
         `CHK("lockout", 1'b1, lockout)
         `CHK("diag", 1'b1, |(diag_o & masks[k]))
         `CHK("out_a", HBC_OFF, out_a)
         `CHK("oe", k < 3, flag_oe)
         sense_i = '0;
         overtemp_i = 1'b0;
         cyc(10);
         `CHK("lockout", 1'b1, lockout)
         `CHK("diag", 1'b1, |(diag_o & masks[k]))
         host_u.reenable(k == 3);
         cyc(3);
         `CHK("lockout", 1'b0, lockout)
         `CHK("diag", 9'h000, diag_o)
         `CHK("out_a", HBC_HIGH, out_a)
      end
      $display("test faults finished");
      wcfg(8'h80);
      host_u.set_pins(4'h6);
      cyc(1);
      `CHK("oe", 1'b1, flag_oe)
      sys_rst_i = 1'b1;
      cyc(1);
      sys_rst_i = 1'b0;
      cyc(1);
      `CHK("cfg_o", 8'h0C, cfg_o)
      `CHK("oe", 1'b0, flag_oe)
      host_u.set_pins(4'hA);
      cyc(2);
      `CHK("out_a", HBC_HIGH, out_a)
      $display("test reset finished");
      complete_run();
   end
endmodule
`default_nettype wire
